/* File: verilog/code_flash_segment_map.sv */
// Program-flash segment classifier for code protection.
// Assumes configuration words are static after reset and addresses are core-clock synchronous.
`default_nettype none
`include "segment_map_params.svh"
module code_flash_segment_map
    import segment_map_pkg::*;
#(
    parameter bit SMALL_VARIANT = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] boot_segment_config_i,
    input wire logic [7:0] general_segment_config_i,
    input wire logic [`ADDR_WIDTH-1:0] addr_i,
    output logic [1:0] segment_o,
    output logic boot_present_o,
    output logic general_present_o,
    output logic [`ADDR_WIDTH-1:0] boot_last_o
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam bounds_type BOUNDS_RESET = '{
        boot_last: `VECTOR_LAST,
        top: (SMALL_VARIANT ? `TOP_SMALL : `TOP_LARGE),
        boot_present: 1'b0
    };

    logic [1:0] size_code_reg;
    logic [1:0] size_code_next;
    bounds_type bounds_next;
    bounds_type bounds_reg;
    logic general_present_reg;
    logic general_present_next;
    segment_type segment_reg;
    segment_type segment_next;
    logic gen_cfg_unused;
    logic [23:0] general_first;
    logic [15:0] boot_words;
    logic [15:0] general_words;

    // ----------------------------------------
    // Configuration capture
    // ----------------------------------------
    // General word sets no boundary; only the boot word sizes segments
    assign gen_cfg_unused = ^general_segment_config_i;

    segment_bounds segment_bounds_inst (
        .size_code_i(size_code_next),
        .small_variant_i(SMALL_VARIANT),
        .bounds_o(bounds_next)
    );

    always_comb begin
        size_code_next = boot_segment_config_i[`SIZE_SEL_LSB +: 2];
        general_present_next = (bounds_next.boot_last != bounds_next.top);
    end

    // Decoded bounds kept in flops so the outputs come from registers
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            size_code_reg <= `SIZE_NONE;
            bounds_reg <= BOUNDS_RESET;
            general_present_reg <= 1'b1;
        end else begin
            size_code_reg <= size_code_next;
            bounds_reg <= bounds_next;
            general_present_reg <= general_present_next;
        end
    end

    // ----------------------------------------
    // Address classification
    // ----------------------------------------
    function automatic segment_type classify(input logic [23:0] a, input bounds_type b);
        if (a > b.top) classify = SEG_NONE;
        else if (a <= `VECTOR_LAST) classify = SEG_VECTOR;
        else if (b.boot_present && a <= b.boot_last) classify = SEG_BOOT;
        else classify = SEG_GENERAL;
    endfunction

    always_comb begin
        segment_next = classify(addr_i, bounds_reg);
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            segment_reg <= SEG_NONE;
        end else begin
            segment_reg <= segment_next;
        end
    end

    // ----------------------------------------
    // Segment sizes in words
    // ----------------------------------------
    // Two address units per word; an empty span counts zero
    function automatic logic [15:0] word_count(input logic [23:0] first,
            input logic [23:0] last);
        logic [23:0] span;
        span = last - first;
        if (last < first) word_count = 16'h0000;
        else word_count = span[16:1] + 16'h0001;
    endfunction

    always_comb begin
        general_first = bounds_reg.boot_last + 24'h000002;
        boot_words = 16'h0000;
        if (bounds_reg.boot_present) begin
            boot_words = word_count(`BOOT_FIRST, bounds_reg.boot_last);
        end
        general_words = word_count(general_first, bounds_reg.top);
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign segment_o = segment_reg;
    assign boot_present_o = bounds_reg.boot_present;
    assign general_present_o = general_present_reg;
    assign boot_last_o = bounds_reg.boot_last;

    // ----------------------------------------
    // Checks: boundaries
    // ----------------------------------------
    boot_768_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        size_code_reg == `SIZE_768
        |-> boot_last_o == `BOOT_LAST_768 && boot_words == `BOOT_WORDS_768)
        else $error("boot bound wrong for 768 words");

    boot_3840_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        size_code_reg == `SIZE_3840
        |-> boot_last_o == `BOOT_LAST_3840 && boot_words == `BOOT_WORDS_3840)
        else $error("boot bound wrong for 3840 words");

    boot_7936_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !SMALL_VARIANT && size_code_reg == `SIZE_MAX
        |-> boot_last_o == `BOOT_LAST_7936 && boot_words == `BOOT_WORDS_7936)
        else $error("boot bound wrong for 7936 words");

    no_boot_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        size_code_reg == `SIZE_NONE |-> !boot_present_o && general_present_o)
        else $error("boot segment present when disabled");

    gen_none_large_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !SMALL_VARIANT && size_code_reg == `SIZE_NONE |-> general_words == `GEN_WORDS_LARGE_NONE)
        else $error("general segment size wrong without boot");

    gen_large_size_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !SMALL_VARIANT && size_code_reg != `SIZE_NONE |-> general_words ==
        (size_code_reg == `SIZE_768 ? `GEN_WORDS_LARGE_768 :
        size_code_reg == `SIZE_3840 ? `GEN_WORDS_LARGE_3840 : `GEN_WORDS_LARGE_MAX))
        else $error("general segment size wrong on large variant");

    gen_small_size_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        SMALL_VARIANT && size_code_reg != `SIZE_MAX |-> general_words ==
        (size_code_reg == `SIZE_NONE ? `GEN_WORDS_SMALL_NONE :
        size_code_reg == `SIZE_768 ? `GEN_WORDS_SMALL_768 : `GEN_WORDS_SMALL_3840))
        else $error("general segment size wrong on small variant");

    small_full_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        SMALL_VARIANT && size_code_reg == `SIZE_MAX
        |-> !general_present_o && boot_words == `BOOT_WORDS_SMALL_MAX
        && general_words == 16'h0000)
        else $error("general segment exists with full boot");

    reset_clear_a: assert property (@(posedge core_clk_i)
        reset_i |=> segment_o == SEG_NONE && !boot_present_o && general_present_o
        && boot_last_o == `VECTOR_LAST)
        else $error("reset does not clear to the no boot layout");

    // ----------------------------------------
    // Checks: classification
    // ----------------------------------------
    // Class lags the address by one edge, hence the past values
    vector_fixed_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        $past(addr_i) <= `VECTOR_LAST && !$past(reset_i) |-> segment_o == SEG_VECTOR)
        else $error("low address not in vector segment");

    boot_member_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !$past(reset_i) && $past(boot_present_o) && $past(addr_i) >= `BOOT_FIRST
        && $past(addr_i) <= $past(boot_last_o) |-> segment_o == SEG_BOOT)
        else $error("boot address not in boot segment");

    gen_start_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !$past(reset_i) && $past(addr_i) == $past(boot_last_o) + 24'h000002
        && $past(addr_i) <= $past(bounds_reg.top) |-> segment_o == SEG_GENERAL)
        else $error("general segment not just above boot");

    top_bound_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !$past(reset_i) && $past(addr_i) == (SMALL_VARIANT ? `TOP_SMALL : `TOP_LARGE)
        |-> segment_o != SEG_NONE && segment_o != SEG_VECTOR)
        else $error("top address wrong");

    three_segments_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !$past(reset_i) && $past(addr_i) <= $past(bounds_reg.top) |-> segment_o != SEG_NONE)
        else $error("implemented address outside all segments");

    beyond_top_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        addr_i > bounds_reg.top && $stable(size_code_reg) |=> segment_o == SEG_NONE)
        else $error("out of range address classified");

    // ----------------------------------------
    // Checks: configuration
    // ----------------------------------------
    cfg_follow_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        1'b1 |=> size_code_reg == $past(boot_segment_config_i[2:1]))
        else $error("size code not from boot config");

    cfg_only_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !$past(reset_i) && $stable(boot_segment_config_i)
        |=> $stable(boot_last_o) && $stable(boot_present_o) && $stable(general_present_o))
        else $error("segment bounds moved without boot config change");

    // ----------------------------------------
    // Cover points
    // ----------------------------------------
    vec_c: cover property (@(posedge core_clk_i) segment_o == SEG_VECTOR);
    boot_c: cover property (@(posedge core_clk_i) segment_o == SEG_BOOT);
    gen_c: cover property (@(posedge core_clk_i) segment_o == SEG_GENERAL);
    none_c: cover property (@(posedge core_clk_i) segment_o == SEG_NONE);
    full_boot_c: cover property (@(posedge core_clk_i) !general_present_o);
endmodule // code_flash_segment_map
`default_nettype wire

/* File: shared/segment_map_params.svh */
// Constants for the program-flash segment map.
// Assumes inclusion from the segment map package and design files only.
// Function
// - The vector segment always holds the first 256 words, 000000h to 0001FEh, whatever the boot size code.
// - On the large variant the low two size bits pick no boot segment, 768, 3840 or 7936 words.
// - On the large variant without a boot segment the general segment spans 000200h to 0057FEh.
// - On the large variant the general segment starts right above the boot segment and ends at 0057FEh.
// - On the small variant the general segment ends at 002BFEh, sized by the boot segment.
// - On the small variant code x00 makes the boot segment fill 000200h to 002BFEh, leaving no general segment.
// - Only the boot configuration word steers the segment settings; the general word is ignored.
// - No secure segment and no secure data RAM exist; only three segments do.
`ifndef SEGMENT_MAP_PARAMS_SVH
`define SEGMENT_MAP_PARAMS_SVH

`define ADDR_WIDTH 24
`define VECTOR_LAST 24'h0001fe
`define BOOT_FIRST 24'h000200
`define BOOT_LAST_768 24'h0007fe
`define BOOT_LAST_3840 24'h001ffe
`define BOOT_LAST_7936 24'h003ffe
`define TOP_LARGE 24'h0057fe
`define TOP_SMALL 24'h002bfe
`define SIZE_NONE 2'h3
`define SIZE_768 2'h2
`define SIZE_3840 2'h1
`define SIZE_MAX 2'h0
`define SIZE_SEL_LSB 1
`define BOOT_CFG_RESET 8'hff
`define BOOT_WORDS_768 16'h0300
`define BOOT_WORDS_3840 16'h0f00
`define BOOT_WORDS_7936 16'h1f00
`define BOOT_WORDS_SMALL_MAX 16'h1500
`define GEN_WORDS_LARGE_NONE 16'h2b00
`define GEN_WORDS_LARGE_768 16'h2800
`define GEN_WORDS_LARGE_3840 16'h1c00
`define GEN_WORDS_LARGE_MAX 16'h0c00
`define GEN_WORDS_SMALL_NONE 16'h1500
`define GEN_WORDS_SMALL_768 16'h1200
`define GEN_WORDS_SMALL_3840 16'h0600

`endif

/* File: shared/segment_map_pkg.sv */
// Types for the program-flash segment map.
// Assumes the params header sits in the include path.
`default_nettype none
package segment_map_pkg;
    typedef enum logic [1:0] {
        SEG_NONE = 2'b00,
        SEG_VECTOR = 2'b01,
        SEG_BOOT = 2'b10,
        SEG_GENERAL = 2'b11
    } segment_type;

    typedef struct packed {
        logic [23:0] boot_last;
        logic [23:0] top;
        logic boot_present;
    } bounds_type;
endpackage
`default_nettype wire

/* File: verilog/segment_bounds.sv */
// Decodes boot size code and variant into segment bounds.
// Assumes static configuration inputs from the same clock domain.
`default_nettype none
`include "segment_map_params.svh"
module segment_bounds
    import segment_map_pkg::*;
(
    input wire logic [1:0] size_code_i,
    input wire logic small_variant_i,
    output bounds_type bounds_o
);
    always_comb begin
        bounds_o.top = small_variant_i ? `TOP_SMALL : `TOP_LARGE;
        bounds_o.boot_present = 1'b1;
        case (size_code_i)
            `SIZE_NONE: begin
                bounds_o.boot_present = 1'b0;
                bounds_o.boot_last = `VECTOR_LAST;
            end
            `SIZE_768: bounds_o.boot_last = `BOOT_LAST_768;
            `SIZE_3840: bounds_o.boot_last = `BOOT_LAST_3840;
            default: bounds_o.boot_last = small_variant_i ? `TOP_SMALL : `BOOT_LAST_7936;
        endcase
    end
endmodule // segment_bounds
`default_nettype wire

/* File: tb/code_flash_segment_map_tb_top.sv */
// Self-checking bench for the flash segment map, both memory variants side by side.
// Assumes the segment map package and params header are compiled first.
`default_nettype none
module code_flash_segment_map_tb_top
    import segment_map_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] bcfg = 8'hff;
    logic [7:0] gcfg = 8'hff;
    logic [23:0] addr = 24'h0;
    logic [1:0] seg_l, seg_s;
    logic bp_l, bp_s, gp_l, gp_s;
    logic [23:0] bl_l, bl_s;
    int bad_count = 0;
    int total_checks = 0;
    // ---------------------------------------------
    // Clock and design instances
    // ---------------------------------------------
    initial forever #25 core_clk_i = ~core_clk_i;
    code_flash_segment_map #(.SMALL_VARIANT(1'b0)) code_flash_segment_map_inst (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .boot_segment_config_i(bcfg),
        .general_segment_config_i(gcfg), .addr_i(addr), .segment_o(seg_l),
        .boot_present_o(bp_l), .general_present_o(gp_l), .boot_last_o(bl_l));
    code_flash_segment_map #(.SMALL_VARIANT(1'b1)) code_flash_segment_map_small_inst (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .boot_segment_config_i(bcfg),
        .general_segment_config_i(gcfg), .addr_i(addr), .segment_o(seg_s),
        .boot_present_o(bp_s), .general_present_o(gp_s), .boot_last_o(bl_s));
    // ---------------------------------------------
    // Shared checking helpers
    // ---------------------------------------------
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [1:0] seg_exp(input logic [23:0] a, last, top);
        if (a <= 24'h0001fe) return SEG_VECTOR;
        if (a <= last) return SEG_BOOT;
        if (a <= top) return SEG_GENERAL;
        return SEG_NONE;
    endfunction
    // Drive at the falling edge; bounds follow one edge later, the class one more
    task automatic probe(input logic [1:0] c, input logic hi, input logic [7:0] g,
            input logic [23:0] a);
        logic [23:0] ll, ls;
        bcfg = {4'hf, hi, c, 1'b1};
        gcfg = g;
        addr = a;
        repeat (2) @(negedge core_clk_i);
        ll = c == 2'h3 ? 24'h0001fe : c == 2'h2 ? 24'h0007fe :
            c == 2'h1 ? 24'h001ffe : 24'h003ffe;
        ls = c == 2'h0 ? 24'h002bfe : ll;
        cmp({22'h0, seg_l}, {22'h0, seg_exp(a, ll, 24'h0057fe)});
        cmp({22'h0, seg_s}, {22'h0, seg_exp(a, ls, 24'h002bfe)});
        cmp(bl_l, ll);
        cmp(bl_s, ls);
        cmp({20'h0, bp_l, bp_s, gp_l, gp_s},
            {20'h0, c != 2'h3, c != 2'h3, 1'b1, c != 2'h0});
    endtask
    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task automatic test_segments(input logic hi, input logic [7:0] g);
        logic [23:0] list [14] = '{24'h0, 24'h1fe, 24'h1ff, 24'h200, 24'h7fe, 24'h800,
            24'h1ffe, 24'h2000, 24'h2bfe, 24'h2c00, 24'h3ffe, 24'h4000, 24'h57fe, 24'h5800};
        for (int c = 0; c < 4; c++) begin
            foreach (list[i]) probe(c[1:0], hi, g, list[i]);
        end
        probe(2'h0, hi, g, 24'hffffff);
        $display("test segments top bit %0d config %h done", hi, g);
    endtask
    task automatic test_mid_reset();
        probe(2'h2, 1'b0, 8'hff, 24'h000200);
        reset_i = 1'b1;
        @(negedge core_clk_i);
        cmp({21'h0, seg_l, bp_l}, 24'h0);
        cmp({21'h0, seg_s, bp_s}, 24'h0);
        reset_i = 1'b0;
        probe(2'h2, 1'b0, 8'hff, 24'h000200);
        $display("test mid reset done");
    endtask
    // ---------------------------------------------
    // Main sequence and verdict
    // ---------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge core_clk_i);
        reset_i = 1'b0;
        test_segments(1'b0, 8'hff);
        test_segments(1'b1, 8'h00);
        test_segments(1'b0, 8'h5a);
        test_mid_reset();
        finish_test();
    end
endmodule // code_flash_segment_map_tb_top
`default_nettype wire
